// *** rmp_pkg.sv ***
package rmp_pkg;

  // Control register map
  localparam logic [7:0] CTRL_ADDR = 8'h07;
  localparam logic [7:0] CTRL_RESET = 8'h80;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // Control register layout, bit 7 first
  typedef struct packed {
    logic gp_out_level;
    logic square_wave_enable;
    logic alarm1_enable;
    logic alarm0_enable;
    logic ext_clock_input_enable;
    logic coarse_trim_enable;
    logic [1:0] square_wave_freq_select;
  } rmp_ctrl_t;

  // Postscaler codes
  typedef enum logic [1:0] {
    FS_DIV_FULL = 2'b00,
    FS_DIV8 = 2'b01,
    FS_DIV4 = 2'b10,
    FS_RAW = 2'b11
  } rmp_fsel_t;

  // Pin modes
  typedef enum logic [1:0] {
    MODE_GPO = 2'b00,
    MODE_ALARM = 2'b01,
    MODE_SQW = 2'b10
  } rmp_mode_t;

  // Postscaler tap positions
  localparam int TAP_DIV8 = 2;
  localparam int TAP_DIV4 = 1;
  localparam int TAP_64HZ = 8;

  // Trim timing: last second index of a normal trim interval
  localparam logic [5:0] SEC_LAST = 6'h3b;
  localparam logic [5:0] SEC_ZERO = 6'h00;

  // Synchroniser lanes
  localparam int LANE_OSC = 0;
  localparam int LANE_EXT = 1;
  localparam int LANE_BKP = 2;
  localparam int LANES = 3;

endpackage

// *** rmp_sync.sv ***
`timescale 1ns/1ns
module rmp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // Two flip-flop stages per lane
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_lane
      always_ff @(posedge sys_clk) begin
        if (!nrst) begin
          meta_r[i] <= 1'b0;
          q[i] <= 1'b0;
        end else begin
          meta_r[i] <= d[i];
          q[i] <= meta_r[i];
        end
      end
    end
  endgenerate
endmodule

// *** rmp_mfp_top.sv ***
`timescale 1ns/1ns
// Function
// (R1) Square-wave enable puts a clock on the pin, over alarm and GPO modes.
// (R2) Frequency select: 00 full divide to 1 Hz, 01 by 8, 10 by 4, 11 undivided.
// (R3) Code 11 carries the raw timebase, untouched by trimming.
// (R4) Divided square-wave outputs come after the trim stage and show corrections.
// (R5) No square wave while running from backup supply.
// (R6) Alarm mode when an alarm is enabled and square wave is off.
// (R7) Alarm output keeps working on backup supply.
// (R8) One alarm, polarity 1: pin equals that alarm's match flag.
// (R9) One alarm, polarity 0: pin is the inverse of that match flag.
// (R10) Both alarms, polarity 1: pin is OR of both flags.
// (R11) Both alarms, polarity 0: pin is NAND of both flags.
// (R12) All enables clear: pin follows the general-purpose output bit.
// (R13) No general-purpose level while running from backup supply.
// (R14) Pin is open drain; high comes only from an external pull-up.
// (R15) External clock enable takes the timebase from the external clock pin.
// (R16) Coarse trim corrects every second; square wave then gives trimmed 64 Hz.
module rmp_mfp_top #(
  parameter int POST_W = 15
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Control register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Timebase and supply pins
  input wire logic osc_clk_in,
  input wire logic ext_clk_in,
  input wire logic on_backup,
  // Alarm and trim state
  input wire logic alarm0_match_flag,
  input wire logic alarm1_match_flag,
  input wire logic alarm_pin_polarity,
  input wire logic trim_subtract,
  input wire logic [6:0] trim_steps,
  // Multi-function pin
  output logic multi_function_pin_o,
  output logic multi_function_pin_oe
);
  localparam int TAP_FULL = POST_W - 1;

  if (POST_W < 9 || POST_W > 16) begin : g_bad_post_w
    $error("POST_W out of range");
  end

  rmp_pkg::rmp_ctrl_t ctrl_r;
  logic [rmp_pkg::LANES-1:0] pins_raw;
  logic [rmp_pkg::LANES-1:0] pins_s;
  logic tb_level;
  logic tb_prev_r;
  logic osc_tick;
  logic bk;
  logic [7:0] pend_r;
  logic sub_r;
  logic ins_done_r;
  logic insert;
  logic drop;
  logic trimmed_tick;
  logic [POST_W-1:0] post_cnt_r;
  logic sec_wrap;
  logic [5:0] sec_cnt_r;
  logic trim_evt_r;
  logic pin_level;
  rmp_pkg::rmp_mode_t mode;

  // Pin mode decode
  function automatic rmp_pkg::rmp_mode_t mode_of(input rmp_pkg::rmp_ctrl_t c);
    if (c.square_wave_enable) begin
      mode_of = rmp_pkg::MODE_SQW; // [R1]
    end else if (c.alarm0_enable || c.alarm1_enable) begin
      mode_of = rmp_pkg::MODE_ALARM; // [R6]
    end else begin
      mode_of = rmp_pkg::MODE_GPO; // [R12]
    end
  endfunction

  // Trimmed square-wave tap
  function automatic logic sq_tap(input rmp_pkg::rmp_ctrl_t c, input logic [POST_W-1:0] n);
    if (c.coarse_trim_enable) begin
      sq_tap = n[rmp_pkg::TAP_64HZ]; // [R16]
    end else begin
      unique case (rmp_pkg::rmp_fsel_t'(c.square_wave_freq_select))
        rmp_pkg::FS_DIV_FULL: sq_tap = n[TAP_FULL]; // [R2]
        rmp_pkg::FS_DIV8: sq_tap = n[rmp_pkg::TAP_DIV8]; // [R2]
        rmp_pkg::FS_DIV4: sq_tap = n[rmp_pkg::TAP_DIV4]; // [R2]
        rmp_pkg::FS_RAW: sq_tap = n[TAP_FULL];
      endcase
    end
  endfunction

  assign mode = mode_of(ctrl_r);

  // Control register
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ctrl_r <= rmp_pkg::rmp_ctrl_t'(rmp_pkg::CTRL_RESET);
    end else if (reg_wr && reg_addr == rmp_pkg::CTRL_ADDR) begin
      ctrl_r <= rmp_pkg::rmp_ctrl_t'(reg_wdata);
    end
  end

  // Read data
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      reg_rdata <= rmp_pkg::READ_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= (reg_addr == rmp_pkg::CTRL_ADDR) ? ctrl_r : rmp_pkg::READ_ZERO;
    end
  end

  // Pin synchronisers
  assign pins_raw = {on_backup, ext_clk_in, osc_clk_in};

  rmp_sync #(
    .W(rmp_pkg::LANES)
  ) u_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .d(pins_raw),
    .q(pins_s)
  );

  assign bk = pins_s[rmp_pkg::LANE_BKP];
  assign tb_level = ctrl_r.ext_clock_input_enable ?
                    pins_s[rmp_pkg::LANE_EXT] : pins_s[rmp_pkg::LANE_OSC]; // [R15]

  // Timebase edge
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      tb_prev_r <= 1'b0;
    end else begin
      tb_prev_r <= tb_level;
    end
  end

  assign osc_tick = tb_level && !tb_prev_r;

  // Trim stage: drop or insert two cycles per step
  assign drop = osc_tick && sub_r && pend_r != 8'h00;
  assign insert = !osc_tick && !sub_r && pend_r != 8'h00 && !ins_done_r;
  assign trimmed_tick = (osc_tick && !drop) || insert; // [R4]

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pend_r <= 8'h00;
      sub_r <= 1'b0;
    end else if (trim_evt_r) begin
      pend_r <= {trim_steps, 1'b0};
      sub_r <= trim_subtract;
    end else if (drop || insert) begin
      pend_r <= pend_r - 8'h01;
    end
  end

  // One inserted cycle per timebase period
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ins_done_r <= 1'b0;
    end else if (osc_tick) begin
      ins_done_r <= 1'b0;
    end else if (insert) begin
      ins_done_r <= 1'b1;
    end
  end

  // Postscaler on trimmed cycles
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      post_cnt_r <= '0;
    end else if (trimmed_tick) begin
      post_cnt_r <= post_cnt_r + 1'b1; // [R4]
    end
  end

  assign sec_wrap = trimmed_tick && (&post_cnt_r);

  // Seconds within trim interval
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      sec_cnt_r <= rmp_pkg::SEC_ZERO;
    end else if (sec_wrap) begin
      sec_cnt_r <= (sec_cnt_r == rmp_pkg::SEC_LAST) ? rmp_pkg::SEC_ZERO : sec_cnt_r + 6'h01;
    end
  end

  // Trim event: each second in coarse mode, else each minute
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      trim_evt_r <= 1'b0;
    end else begin
      trim_evt_r <= sec_wrap &&
                    (ctrl_r.coarse_trim_enable || sec_cnt_r == rmp_pkg::SEC_LAST); // [R16]
    end
  end

  // Pin level selection
  always_comb begin
    pin_level = 1'b1;
    unique case (mode)
      rmp_pkg::MODE_SQW: begin
        if (bk) begin
          pin_level = 1'b1; // [R5]
        end else if (!ctrl_r.coarse_trim_enable &&
                     ctrl_r.square_wave_freq_select == rmp_pkg::FS_RAW) begin
          pin_level = tb_level; // [R3]
        end else begin
          pin_level = sq_tap(ctrl_r, post_cnt_r); // [R1]
        end
      end
      rmp_pkg::MODE_ALARM: begin
        if (ctrl_r.alarm0_enable && ctrl_r.alarm1_enable) begin
          pin_level = alarm_pin_polarity ? (alarm0_match_flag || alarm1_match_flag) // [R10]
                                         : !(alarm0_match_flag && alarm1_match_flag); // [R11]
        end else begin
          pin_level = (ctrl_r.alarm0_enable ? alarm0_match_flag : alarm1_match_flag) ==
                      alarm_pin_polarity; // [R8] [R9] [R7]
        end
      end
      rmp_pkg::MODE_GPO: begin
        pin_level = bk ? 1'b1 : ctrl_r.gp_out_level; // [R12] [R13]
      end
    endcase
  end

  // Open-drain driver: low when enabled, released otherwise
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      multi_function_pin_o <= 1'b0;
      multi_function_pin_oe <= 1'b0;
    end else begin
      multi_function_pin_o <= 1'b0; // [R14]
      multi_function_pin_oe <= !pin_level; // [R14]
    end
  end

  // Checks
  sequence s_raw_sqw;
    mode == rmp_pkg::MODE_SQW && !bk && !ctrl_r.coarse_trim_enable &&
      ctrl_r.square_wave_freq_select == rmp_pkg::FS_RAW;
  endsequence

  sequence s_alarm_one;
    mode == rmp_pkg::MODE_ALARM && (ctrl_r.alarm0_enable != ctrl_r.alarm1_enable);
  endsequence

  sequence s_alarm_two;
    mode == rmp_pkg::MODE_ALARM && ctrl_r.alarm0_enable && ctrl_r.alarm1_enable;
  endsequence

  sqw_backup_off_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R5]
    mode == rmp_pkg::MODE_SQW && bk |=> !multi_function_pin_oe)
    else $error("square wave driven on backup");

  raw_bypass_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R3]
    s_raw_sqw |=> multi_function_pin_oe == !$past(tb_level))
    else $error("raw clock not on pin");

  one_alarm_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R8]
    s_alarm_one ##0 alarm_pin_polarity |=>
      multi_function_pin_oe == !$past(ctrl_r.alarm0_enable ? alarm0_match_flag
                                                           : alarm1_match_flag))
    else $error("single alarm polarity 1 wrong");

  one_alarm_inv_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R9]
    s_alarm_one ##0 !alarm_pin_polarity |=>
      multi_function_pin_oe == $past(ctrl_r.alarm0_enable ? alarm0_match_flag
                                                          : alarm1_match_flag))
    else $error("single alarm polarity 0 wrong");

  dual_or_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R10]
    s_alarm_two ##0 alarm_pin_polarity |=>
      multi_function_pin_oe == !$past(alarm0_match_flag || alarm1_match_flag))
    else $error("dual alarm OR wrong");

  dual_nand_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R11]
    s_alarm_two ##0 !alarm_pin_polarity |=>
      multi_function_pin_oe == $past(alarm0_match_flag && alarm1_match_flag))
    else $error("dual alarm NAND wrong");

  alarm_backup_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R7]
    s_alarm_two ##0 bk && alarm_pin_polarity && alarm0_match_flag |=>
      !multi_function_pin_oe)
    else $error("alarm output lost on backup");

  gpo_level_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R12]
    mode == rmp_pkg::MODE_GPO && !bk |=> multi_function_pin_oe == !$past(ctrl_r.gp_out_level))
    else $error("general-purpose level wrong");

  gpo_backup_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R13]
    mode == rmp_pkg::MODE_GPO && bk |=> !multi_function_pin_oe)
    else $error("general-purpose output on backup");

  sqw_priority_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R1]
    ctrl_r.square_wave_enable && ctrl_r.alarm0_enable && !bk && ctrl_r.coarse_trim_enable |=>
      multi_function_pin_oe == !$past(post_cnt_r[rmp_pkg::TAP_64HZ]))
    else $error("square wave lost priority");

  trim_drop_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R4]
    osc_tick && sub_r && pend_r != 8'h00 && !trim_evt_r |=>
      post_cnt_r == $past(post_cnt_r) && pend_r == $past(pend_r) - 8'h01)
    else $error("trim drop not applied");

  coarse_evt_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R16]
    sec_wrap && ctrl_r.coarse_trim_enable |=> trim_evt_r ##1 pend_r == {$past(trim_steps), 1'b0})
    else $error("coarse trim event missing");

  ext_sel_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R15]
    ctrl_r.ext_clock_input_enable && $past(ctrl_r.ext_clock_input_enable) &&
      $rose(pins_s[rmp_pkg::LANE_EXT]) |-> osc_tick)
    else $error("external timebase not used");

  pin_low_only_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R14]
    ##1 !multi_function_pin_o)
    else $error("pin driven high");
endmodule

// *** rmp_host_model.sv ***
`timescale 1ns/1ns
module rmp_host_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Device pin
  input wire logic pin_o,
  input wire logic pin_oe,
  // Host view
  output logic pin_level,
  output logic [15:0] rise_count
);
  logic prev_r;
  // Pull-up gives the only high level
  assign pin_level = pin_oe ? pin_o : 1'b1;
  // Counts rising pin edges
  always_ff @(posedge sys_clk) begin
    prev_r <= pin_level;
    if (!nrst) begin
      rise_count <= 16'h0000;
    end else if (pin_level && !prev_r) begin
      rise_count <= rise_count + 16'h0001;
    end
  end
endmodule

// *** rtc_multifunction_pin_output_test.sv ***
`timescale 1ns/1ns
module rtc_multifunction_pin_output_test;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic osc = 1'b0;
  logic ext = 1'b0;
  logic bkp = 1'b0;
  logic f0 = 1'b0;
  logic f1 = 1'b0;
  logic pol = 1'b0;
  logic tsub = 1'b0;
  logic [6:0] tstep = 7'h00;
  logic pin_o, pin_oe, pin_level;
  logic rd_pend = 1'b0;
  logic [1:0] odiv = 2'h0;
  logic [1:0] ediv = 2'h0;
  logic [15:0] rises, c0, cnt_seen, ce;
  logic [7:0] d;
  logic e;
  int fail_count = 0;
  int samples_checked = 0;
  logic [15:0] q_rd[$];
  logic [15:0] q_pin[$];
  logic [15:0] q_cnt[$];
  event pin_ev, cnt_ev;

  always #2 sys_clk = ~sys_clk;
  // Timebases: oscillator 8 cycles, external 6 cycles
  always @(posedge sys_clk) begin
    odiv <= odiv + 2'h1;
    if (odiv == 2'h3) osc <= ~osc;
    ediv <= (ediv == 2'h2) ? 2'h0 : ediv + 2'h1;
    if (ediv == 2'h2) ext <= ~ext;
  end

  // Narrow postscaler keeps full divide and trim events inside the run
  rmp_mfp_top #(.POST_W(10)) i_dut (
    .sys_clk(sys_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .osc_clk_in(osc), .ext_clk_in(ext), .on_backup(bkp),
    .alarm0_match_flag(f0), .alarm1_match_flag(f1), .alarm_pin_polarity(pol),
    .trim_subtract(tsub), .trim_steps(tstep),
    .multi_function_pin_o(pin_o), .multi_function_pin_oe(pin_oe)
  );
  rmp_host_model i_host (
    .sys_clk(sys_clk), .nrst(nrst), .pin_o(pin_o), .pin_oe(pin_oe),
    .pin_level(pin_level), .rise_count(rises)
  );

  task check(string name, logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task cyc(int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task wr(logic [7:0] a, logic [7:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task rd(logic [7:0] a, logic [7:0] v);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    q_rd.push_back({8'h00, v});
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask

  task exp_pin(logic v);
    cyc(6);
    q_pin.push_back({15'h0000, v});
    @(negedge sys_clk);
    ->pin_ev;
    @(posedge sys_clk);
  endtask

  task freq(logic [7:0] c, logic [15:0] v, int n);
    wr(8'h07, c);
    cyc(40);
    c0 = rises;
    cyc(n);
    q_cnt.push_back(v);
    cnt_seen = rises - c0;
    @(negedge sys_clk);
    ->cnt_ev;
    @(posedge sys_clk);
  endtask

  // Output watchers
  always @(posedge sys_clk) begin
    if (rd_pend) check("rdata", {8'h00, reg_rdata}, q_rd.pop_front());
    rd_pend <= reg_rd;
  end
  always begin
    @(pin_ev);
    check("pin", {15'h0000, pin_level}, q_pin.pop_front());
  end
  always begin
    @(cnt_ev);
    ce = q_cnt.pop_front();
    check("freq", (cnt_seen + 16'h1 >= ce && cnt_seen <= ce + 16'h1) ? ce : cnt_seen, ce);
  end

  initial begin
    void'($urandom(32'h022a));
    cyc(8);
    nrst <= 1'b1;
    exp_pin(1'b1);
    rd(8'h07, 8'h80);
    rd(8'h33, 8'h00);
    wr(8'h33, 8'h00);
    rd(8'h07, 8'h80);
    d = 8'($urandom);
    wr(8'h07, d);
    rd(8'h07, d);
    for (int i = 0; i < 4; i++) begin
      bkp <= i[1];
      wr(8'h07, {i[0], 7'h00});
      exp_pin(i[1] | i[0]);
    end
    // Every enable pair, polarity and flag pattern
    for (int i = 0; i < 24; i++) begin
      {pol, f1, f0} <= i[2:0];
      bkp <= 1'($urandom);
      tsub <= 1'($urandom);
      case (i / 8)
        0: e = i[2] ? i[0] : ~i[0];
        1: e = i[2] ? i[1] : ~i[1];
        default: e = i[2] ? (i[0] | i[1]) : ~(i[0] & i[1]);
      endcase
      wr(8'h07, {~e, 1'b0, 2'(i / 8 + 1), 4'h0});
      exp_pin(e);
    end
    bkp <= 1'b0;
    {pol, f1, f0} <= 3'b100;
    freq(8'h73, 16'd128, 1024);
    freq(8'h72, 16'd32, 1024);
    freq(8'h71, 16'd16, 1024);
    freq(8'h70, 16'd2, 16384);
    freq(8'h4b, 16'd170, 1024);
    tstep <= 7'($urandom_range(7, 1));
    tsub <= 1'b1;
    freq(8'h54, 16'd4, 16384);
    bkp <= 1'b1;
    freq(8'h43, 16'd0, 1024);
    exp_pin(1'b1);
    end_sim;
  end

  initial begin
    cyc(100000);
    fail_count++;
    end_sim;
  end
endmodule
